// >>> rtl/lcdsd_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "lcdsd_params.svh"
// Function
// - static, 2-, 3-, 4-mux panels, the multiplexed ones with half or third bias
// - all display timing comes from the real-time clock oscillator
// - clock divider field: 00 by 1, 01 by 2, 10 by 4, 11 reserved
// - waveforms generated in hardware from current segment data every frame
// - blinking supported besides steady on and off
// - display driven only once master control bit 0 is one
// - refresh rate set by high and low divider registers on display clock
// - software can disable supply comparator via config register
// - sixteen byte registers, one nibble per segment pin, 32 pins
// - nibble bit n controls segment on backplane n
// - mux mode selects how many low nibble bits are used
// - data bit one turns segment on, zero turns it off
// - mux field 00 static, 01 2-mux, 10 3-mux, 11 4-mux
// - blank bit one forces every segment off
// - size bit selects 16 or 32 segment pins
module lcdsd_top #(
    parameter int NPINS = `LCDSD_NUM_PINS,
    parameter int NCOMS = `LCDSD_NUM_COMS
) (
    // clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    // real-time clock oscillator, asynchronous
    input  wire logic              rtc_clk_i,
    // sfr bus
    input  wire logic [7:0]        sfr_addr_i,
    input  wire logic [7:0]        sfr_page_i,
    input  wire logic              sfr_wr_i,
    input  wire logic              sfr_rd_i,
    input  wire logic [7:0]        sfr_wdata_i,
    output logic      [7:0]        sfr_rdata_o,
    output logic                   sfr_hit_o,
    // level codes to the analog drivers
    output logic [2*NPINS-1:0]     seg_level_o,
    output logic [2*NCOMS-1:0]     com_level_o,
    output logic [NPINS-1:0]       seg_pin_en_o,
    // analog controls
    output logic                   bias_half_o,
    output logic                   bias_en_o,
    output logic                   drive_en_o,
    output logic                   supply_cmp_dis_o,
    output logic [7:0]             contrast_o
);
    localparam int NREG = `LCDSD_NUM_DATA;

    logic [7:0] data_q [NREG];
    logic [7:0] ctrl_q;
    logic [7:0] master_q;
    logic [7:0] config_q;
    logic [7:0] contrast_q;
    logic [7:0] divh_q;
    logic [7:0] divl_q;
    logic [7:0] blink_q;
    logic [7:0] blinkdiv_q;

    logic       page_ok;
    logic [4:0] data_idx;
    logic       data_hit;

    assign page_ok = (sfr_page_i == `LCDSD_SFR_PAGE);

    // address decode for the scattered data registers
    always_comb begin
        data_hit = 1'b1;
        data_idx = 5'h00;
        unique case (sfr_addr_i)
            `LCDSD_ADDR_DATA0:  data_idx = 5'h00;
            `LCDSD_ADDR_DATA1:  data_idx = 5'h01;
            `LCDSD_ADDR_DATA2:  data_idx = 5'h02;
            `LCDSD_ADDR_DATA3:  data_idx = 5'h03;
            `LCDSD_ADDR_DATA4:  data_idx = 5'h04;
            `LCDSD_ADDR_DATA5:  data_idx = 5'h05;
            `LCDSD_ADDR_DATA6:  data_idx = 5'h06;
            `LCDSD_ADDR_DATA7:  data_idx = 5'h07;
            `LCDSD_ADDR_DATA8:  data_idx = 5'h08;
            `LCDSD_ADDR_DATA9:  data_idx = 5'h09;
            `LCDSD_ADDR_DATA10: data_idx = 5'h0a;
            `LCDSD_ADDR_DATA11: data_idx = 5'h0b;
            `LCDSD_ADDR_DATA12: data_idx = 5'h0c;
            `LCDSD_ADDR_DATA13: data_idx = 5'h0d;
            `LCDSD_ADDR_DATA14: data_idx = 5'h0e;
            `LCDSD_ADDR_DATA15: data_idx = 5'h0f;
            default:            data_hit = 1'b0;
        endcase
    end

    // segment data storage
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NREG; i++) begin
                data_q[i] <= `LCDSD_RESET_BYTE;
            end
        end else if (sfr_wr_i && page_ok && data_hit) begin
            data_q[data_idx[3:0]] <= sfr_wdata_i;
        end
    end

    // control registers
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q     <= `LCDSD_RESET_BYTE;
            master_q   <= `LCDSD_RESET_BYTE;
            config_q   <= `LCDSD_RESET_BYTE;
            contrast_q <= `LCDSD_RESET_BYTE;
            divh_q     <= `LCDSD_RESET_BYTE;
            divl_q     <= `LCDSD_RESET_BYTE;
            blink_q    <= `LCDSD_RESET_BYTE;
            blinkdiv_q <= `LCDSD_RESET_BYTE;
        end else if (sfr_wr_i && page_ok) begin
            unique case (sfr_addr_i)
                `LCDSD_ADDR_CTRL:     ctrl_q     <= sfr_wdata_i & `LCDSD_CTRL_MASK;
                `LCDSD_ADDR_MASTER:   master_q   <= sfr_wdata_i;
                `LCDSD_ADDR_CONFIG:   config_q   <= sfr_wdata_i;
                `LCDSD_ADDR_CONTRAST: contrast_q <= sfr_wdata_i;
                `LCDSD_ADDR_DIVH:     divh_q     <= sfr_wdata_i;
                `LCDSD_ADDR_DIVL:     divl_q     <= sfr_wdata_i;
                `LCDSD_ADDR_BLINK:    blink_q    <= sfr_wdata_i;
                `LCDSD_ADDR_BLINKDIV: blinkdiv_q <= sfr_wdata_i;
                default: ;
            endcase
        end
    end

    // read mux, registered
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sfr_rdata_o <= 8'h00;
            sfr_hit_o   <= 1'b0;
        end else begin
            sfr_rdata_o <= 8'h00;
            sfr_hit_o   <= 1'b0;
            if (sfr_rd_i && page_ok) begin
                sfr_hit_o <= 1'b1;
                if (data_hit) begin
                    sfr_rdata_o <= data_q[data_idx[3:0]];
                end else begin
                    unique case (sfr_addr_i)
                        `LCDSD_ADDR_CTRL:     sfr_rdata_o <= ctrl_q;
                        `LCDSD_ADDR_MASTER:   sfr_rdata_o <= master_q;
                        `LCDSD_ADDR_CONFIG:   sfr_rdata_o <= config_q;
                        `LCDSD_ADDR_CONTRAST: sfr_rdata_o <= contrast_q;
                        `LCDSD_ADDR_DIVH:     sfr_rdata_o <= divh_q;
                        `LCDSD_ADDR_DIVL:     sfr_rdata_o <= divl_q;
                        `LCDSD_ADDR_BLINK:    sfr_rdata_o <= blink_q;
                        `LCDSD_ADDR_BLINKDIV: sfr_rdata_o <= blinkdiv_q;
                        default:              sfr_hit_o   <= 1'b0;
                    endcase
                end
            end
        end
    end

    // decoded fields
    logic                 enable;
    logic                 blank;
    logic                 size32;
    logic                 bias_half;
    lcdsd_pkg::lcdsd_mux_e  mux;
    lcdsd_pkg::lcdsd_cdiv_e cdiv;

    assign enable    = master_q[`LCDSD_MST_ENABLE];
    assign blank     = ctrl_q[`LCDSD_CTRL_BLANK];
    assign size32    = ctrl_q[`LCDSD_CTRL_SIZE];
    assign bias_half = ctrl_q[`LCDSD_CTRL_BIAS];
    assign mux  = lcdsd_pkg::lcdsd_mux_e'(ctrl_q[`LCDSD_CTRL_MUX_HI:`LCDSD_CTRL_MUX_LO]);
    assign cdiv = lcdsd_pkg::lcdsd_cdiv_e'(ctrl_q[`LCDSD_CTRL_CDIV_HI:`LCDSD_CTRL_CDIV_LO]);

    // rtc edge detection after synchroniser
    logic rtc_lvl;
    logic rtc_prev_q;
    logic rtc_tick;

    lcdsd_sync u_sync (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .d_i    (rtc_clk_i),
        .q_o    (rtc_lvl)
    );

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rtc_prev_q <= 1'b0;
        end else begin
            rtc_prev_q <= rtc_lvl;
        end
    end

    assign rtc_tick = rtc_lvl & ~rtc_prev_q;

    // prescaler by 1, 2 or 4
    logic [1:0] pre_q;
    logic       lcd_tick;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_q <= 2'h0;
        end else if (!enable) begin
            pre_q <= 2'h0;
        end else if (rtc_tick) begin
            pre_q <= pre_q + 2'h1;
        end
    end

    always_comb begin
        unique case (cdiv)
            lcdsd_pkg::LCDSD_DIV1: lcd_tick = rtc_tick;
            lcdsd_pkg::LCDSD_DIV2: lcd_tick = rtc_tick & pre_q[0];
            lcdsd_pkg::LCDSD_DIV4: lcd_tick = rtc_tick & (&pre_q);
            lcdsd_pkg::LCDSD_DIVR: lcd_tick = 1'b0;
        endcase
    end

    // refresh divider: one tick per waveform phase
    logic phase_tick;

    lcdsd_divider #(.WIDTH(16)) u_refresh (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .run_i  (enable),
        .tick_i (lcd_tick),
        .div_i  ({divh_q, divl_q}),
        .tick_o (phase_tick)
    );

    // phase: backplane index and polarity half
    logic [1:0] com_q;
    logic       inv_q;
    logic [1:0] last_com;

    always_comb begin
        unique case (mux)
            lcdsd_pkg::LCDSD_STATIC: last_com = 2'h0;
            lcdsd_pkg::LCDSD_MUX2:   last_com = 2'h1;
            lcdsd_pkg::LCDSD_MUX3:   last_com = 2'h2;
            lcdsd_pkg::LCDSD_MUX4:   last_com = 2'h3;
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            com_q <= 2'h0;
            inv_q <= 1'b0;
        end else if (!enable) begin
            com_q <= 2'h0;
            inv_q <= 1'b0;
        end else if (com_q > last_com) begin
            com_q <= 2'h0;
        end else if (phase_tick) begin
            if (com_q >= last_com) begin
                com_q <= 2'h0;
                inv_q <= ~inv_q;
            end else begin
                com_q <= com_q + 2'h1;
            end
        end
    end

    // blink: counts frames, toggles phase
    logic [7:0] blink_cnt_q;
    logic       blink_off_q;
    logic       frame_end;

    assign frame_end = phase_tick & (com_q >= last_com) & inv_q;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            blink_cnt_q <= 8'h00;
            blink_off_q <= 1'b0;
        end else if (!enable) begin
            blink_cnt_q <= 8'h00;
            blink_off_q <= 1'b0;
        end else if (frame_end) begin
            if (blink_cnt_q >= blinkdiv_q) begin
                blink_cnt_q <= 8'h00;
                blink_off_q <= ~blink_off_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 8'h01;
            end
        end
    end

    // waveform level codes: 0 = lowest rail, 3 = display_supply
    function automatic lcdsd_pkg::lcdsd_level_t seg_lvl(input logic on, input logic inv,
                                                        input logic stat, input logic half);
        logic sel;
        sel = on ^ inv;
        if (stat) begin
            seg_lvl = sel ? 2'h3 : 2'h0;
        end else if (half) begin
            seg_lvl = sel ? 2'h3 : 2'h0;
        end else begin
            seg_lvl = sel ? 2'h3 : 2'h1;
        end
        if (inv && !stat && !half) begin
            seg_lvl = on ? 2'h0 : 2'h2;
        end
    endfunction : seg_lvl

    function automatic lcdsd_pkg::lcdsd_level_t com_lvl(input logic act, input logic inv,
                                                        input logic stat, input logic half);
        if (act || stat) begin
            com_lvl = inv ? 2'h3 : 2'h0;
        end else if (half) begin
            com_lvl = 2'h1;
        end else begin
            com_lvl = inv ? 2'h1 : 2'h2;
        end
    endfunction : com_lvl

    logic stat;
    assign stat = (mux == lcdsd_pkg::LCDSD_STATIC);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            seg_level_o  <= '0;
            com_level_o  <= '0;
            seg_pin_en_o <= '0;
        end else begin
            for (int p = 0; p < NPINS; p++) begin
                logic [3:0] nib;
                logic       on;
                nib = p[0] ? data_q[p/2][7:4] : data_q[p/2][3:0];
                on  = nib[com_q] & ~blank & ~(blink_q[p/4] & blink_off_q);
                seg_level_o[2*p +: 2] <= seg_lvl(on, inv_q, stat, bias_half);
                seg_pin_en_o[p] <= enable & (size32 | (p < `LCDSD_SMALL_PINS));
            end
            for (int c = 0; c < NCOMS; c++) begin
                com_level_o[2*c +: 2] <= (c > last_com) ? 2'h0 :
                    com_lvl(com_q == c[1:0], inv_q, stat, bias_half);
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bias_half_o      <= 1'b0;
            bias_en_o        <= 1'b0;
            drive_en_o       <= 1'b0;
            supply_cmp_dis_o <= 1'b0;
            contrast_o       <= 8'h00;
        end else begin
            bias_half_o      <= bias_half & ~stat;
            bias_en_o        <= master_q[`LCDSD_MST_BIASEN];
            drive_en_o       <= enable;
            supply_cmp_dis_o <= config_q[`LCDSD_CFG_CMPDIS];
            contrast_o       <= contrast_q;
        end
    end

    a_drive_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
        !master_q[`LCDSD_MST_ENABLE] |=> !drive_en_o && seg_pin_en_o == '0)
        else $error("display driven while disabled");

    a_size_small: assert property (@(posedge mclk_i) disable iff (rst_i)
        !size32 |=> seg_pin_en_o[NPINS-1:`LCDSD_SMALL_PINS] == '0)
        else $error("upper pins enabled in 16-pin size");

    a_com_range: assert property (@(posedge mclk_i) disable iff (rst_i)
        com_q <= last_com || $changed(mux))
        else $error("backplane index beyond mux mode");

    a_reserved_div: assert property (@(posedge mclk_i) disable iff (rst_i)
        cdiv == lcdsd_pkg::LCDSD_DIVR |-> !lcd_tick)
        else $error("clock runs with reserved divider");

    a_div4_spacing: assert property (@(posedge mclk_i) disable iff (rst_i)
        cdiv == lcdsd_pkg::LCDSD_DIV4 && lcd_tick |=> pre_q == 2'h0)
        else $error("divide-by-4 prescaler did not wrap");

    a_cmp_disable: assert property (@(posedge mclk_i) disable iff (rst_i)
        ##1 supply_cmp_dis_o == $past(config_q[`LCDSD_CFG_CMPDIS]))
        else $error("comparator disable not following config");

    a_data_write: assert property (@(posedge mclk_i) disable iff (rst_i)
        sfr_wr_i && page_ok && data_hit |=> data_q[$past(data_idx[3:0])] == $past(sfr_wdata_i))
        else $error("segment data write lost");

    a_refresh_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
        !enable |=> com_q == 2'h0 && !phase_tick)
        else $error("refresh runs while disabled");
endmodule : lcdsd_top
`default_nettype wire

// >>> rtl/lcdsd_params.svh
`ifndef LCDSD_PARAMS_SVH
`define LCDSD_PARAMS_SVH

// sfr addresses on page 2
`define LCDSD_SFR_PAGE        8'h02
`define LCDSD_ADDR_DATA0      8'h89
`define LCDSD_ADDR_DATA1      8'h8a
`define LCDSD_ADDR_DATA2      8'h8b
`define LCDSD_ADDR_DATA3      8'h8c
`define LCDSD_ADDR_DATA4      8'h8d
`define LCDSD_ADDR_DATA5      8'h8e
`define LCDSD_ADDR_DATA6      8'h91
`define LCDSD_ADDR_DATA7      8'h92
`define LCDSD_ADDR_DATA8      8'h93
`define LCDSD_ADDR_DATA9      8'h94
`define LCDSD_ADDR_DATA10     8'h95
`define LCDSD_ADDR_DATA11     8'h96
`define LCDSD_ADDR_DATA12     8'h97
`define LCDSD_ADDR_DATA13     8'h99
`define LCDSD_ADDR_DATA14     8'h9a
`define LCDSD_ADDR_DATA15     8'h9b
`define LCDSD_ADDR_CTRL       8'h9d
`define LCDSD_ADDR_MASTER     8'h9e
`define LCDSD_ADDR_CONFIG     8'h9f
`define LCDSD_ADDR_CONTRAST   8'ha1
`define LCDSD_ADDR_DIVH       8'ha2
`define LCDSD_ADDR_DIVL       8'ha3
`define LCDSD_ADDR_BLINK      8'ha4
`define LCDSD_ADDR_BLINKDIV   8'ha5

// display_control fields
`define LCDSD_CTRL_BIAS       0
`define LCDSD_CTRL_MUX_LO     1
`define LCDSD_CTRL_MUX_HI     2
`define LCDSD_CTRL_SIZE       3
`define LCDSD_CTRL_BLANK      4
`define LCDSD_CTRL_CDIV_LO    5
`define LCDSD_CTRL_CDIV_HI    6
`define LCDSD_CTRL_MASK       8'h7f

// master control fields
`define LCDSD_MST_ENABLE      0
`define LCDSD_MST_CLKGATE     4
`define LCDSD_MST_BIASEN      6

// config fields
`define LCDSD_CFG_CMPDIS      0

`define LCDSD_RESET_BYTE      8'h00
`define LCDSD_NUM_DATA        16
`define LCDSD_NUM_PINS        32
`define LCDSD_NUM_COMS        4
`define LCDSD_SMALL_PINS      16

`endif

// >>> rtl/lcdsd_pkg.sv
package lcdsd_pkg;
    typedef enum logic [1:0] {
        LCDSD_DIV1 = 2'h0,
        LCDSD_DIV2 = 2'h1,
        LCDSD_DIV4 = 2'h2,
        LCDSD_DIVR = 2'h3
    } lcdsd_cdiv_e;

    typedef enum logic [1:0] {
        LCDSD_STATIC = 2'h0,
        LCDSD_MUX2   = 2'h1,
        LCDSD_MUX3   = 2'h2,
        LCDSD_MUX4   = 2'h3
    } lcdsd_mux_e;

    // level code driven to analog: 0..3 of the bias ladder
    typedef logic [1:0] lcdsd_level_t;
endpackage : lcdsd_pkg

// >>> rtl/lcdsd_sync.sv
`timescale 1ns/1ns
`default_nettype none
// three-stage input synchroniser; change accepted when stage 2 and 3 agree
module lcdsd_sync (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // async input
    input  wire logic d_i,
    // filtered level
    output logic      q_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q_o <= 1'b0;
        end else if (s2_q == s3_q) begin
            q_o <= s3_q;
        end
    end
endmodule : lcdsd_sync
`default_nettype wire

// >>> rtl/lcdsd_divider.sv
`timescale 1ns/1ns
`default_nettype none
// programmable tick divider: one pulse every (div_i + 1) input ticks
module lcdsd_divider #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    // control
    input  wire logic             run_i,
    input  wire logic             tick_i,
    input  wire logic [WIDTH-1:0] div_i,
    // output tick
    output logic                  tick_o
);
    logic [WIDTH-1:0] cnt_q;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (tick_i) begin
                if (cnt_q >= div_i) begin
                    cnt_q  <= '0;
                    tick_o <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule : lcdsd_divider
`default_nettype wire

// >>> bench/lcdsd_glass.sv
`timescale 1ns/1ns
`default_nettype none
// passive glass: a pixel lights once both drive polarities reach full swing
module lcdsd_glass (
    // clock and clear
    input  wire logic         mclk_i,
    input  wire logic         clr_i,
    // pins
    input  wire logic [63:0]  seg_level_i,
    input  wire logic [7:0]   com_level_i,
    input  wire logic [31:0]  seg_en_i,
    // seen state
    output logic      [127:0] lit_o,
    output logic      [15:0]  steps_o
);
    logic [127:0] pos_q;
    logic [127:0] neg_q;
    logic [7:0]   com_q;

    assign lit_o = pos_q & neg_q;

    always_ff @(posedge mclk_i) begin
        com_q <= com_level_i;
        if (clr_i) begin
            pos_q <= '0;
            neg_q <= '0;
            steps_o <= '0;
        end else begin
            if (com_level_i != com_q)
                steps_o <= steps_o + 16'h1;
            for (int p = 0; p < 32; p++) begin
                for (int k = 0; k < 4; k++) begin
                    // undriven pins leave the glass dark
                    if (seg_en_i[p] && seg_level_i[2*p+:2] == 2'h3 &&
                        com_level_i[2*k+:2] == 2'h0)
                        pos_q[4*p+k] <= 1'b1;
                    if (seg_en_i[p] && seg_level_i[2*p+:2] == 2'h0 &&
                        com_level_i[2*k+:2] == 2'h3)
                        neg_q[4*p+k] <= 1'b1;
                end
            end
        end
    end
endmodule : lcdsd_glass
`default_nettype wire

// >>> bench/lcd_segment_driver_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module lcd_segment_driver_test;
    logic         mclk;
    logic         rst;
    logic         rtc_clk;
    logic [7:0]   addr;
    logic [7:0]   page;
    logic         wr;
    logic         rd;
    logic [7:0]   wdata;
    logic [7:0]   rdata;
    logic         hit;
    logic [63:0]  seg_level;
    logic [7:0]   com_level;
    logic [31:0]  pin_en;
    logic         bias_half;
    logic         bias_en;
    logic         drive_en;
    logic         cmp_dis;
    logic [7:0]   contrast;
    logic         clr;
    logic [127:0] lit;
    logic [15:0]  steps;
    logic [15:0]  steps1;
    logic [7:0]   d;
    logic [3:0]   nm;
    int           err_total;
    int           n_compared;
    int           cyc;
    // addr, write data, expected read, expected hit
    localparam logic [31:0] ROWS [10] = '{32'h895a5a01, 32'h8ec3c301, 32'h913c3c01,
        32'h9bffff01, 32'h9dff7f01, 32'h90aa0000, 32'h98550000, 32'ha1777701,
        32'ha2000001, 32'ha3010101};
    localparam logic [7:0] DADDR [16] = '{8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e,
        8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'h99, 8'h9a, 8'h9b};

    lcdsd_top dut (.mclk_i(mclk), .rst_i(rst), .rtc_clk_i(rtc_clk), .sfr_addr_i(addr),
        .sfr_page_i(page), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata),
        .sfr_rdata_o(rdata), .sfr_hit_o(hit), .seg_level_o(seg_level),
        .com_level_o(com_level), .seg_pin_en_o(pin_en), .bias_half_o(bias_half),
        .bias_en_o(bias_en), .drive_en_o(drive_en), .supply_cmp_dis_o(cmp_dis),
        .contrast_o(contrast));
    lcdsd_glass glass (.mclk_i(mclk), .clr_i(clr), .seg_level_i(seg_level),
        .com_level_i(com_level), .seg_en_i(pin_en), .lit_o(lit), .steps_o(steps));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // oscillator unrelated in phase to the system clock
    initial begin
        rtc_clk = 1'b0;
        forever #165 rtc_clk = ~rtc_clk;
    end

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v, input logic [7:0] pg);
        @(posedge mclk);
        addr <= a;
        page <= pg;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : sfr_wr

    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] pg, output logic [7:0] v,
                          output logic h);
        @(posedge mclk);
        addr <= a;
        page <= pg;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        v = rdata;
        h = hit;
    endtask : sfr_rd

    // new control value, settle, then watch the glass for 1200 cycles
    task automatic show(input logic [7:0] c);
        sfr_wr(8'h9d, c, 8'h02);
        repeat (50) @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        repeat (1200) @(posedge mclk);
        #1;
    endtask : show

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            tally_and_finish();
        end
    end

    initial begin
        logic h;
        rst = 1'b1;
        addr = 8'h00;
        page = 8'h02;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h00;
        clr = 1'b0;
        err_total = 0;
        n_compared = 0;
        cyc = 0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        foreach (DADDR[i]) begin
            sfr_rd(DADDR[i], 8'h02, d, h);
            `CHK(d, 8'h00)
        end
        $display("reset values done");
        foreach (ROWS[i]) begin
            sfr_wr(ROWS[i][31:24], ROWS[i][23:16], 8'h02);
            sfr_rd(ROWS[i][31:24], 8'h02, d, h);
            `CHK(d, ROWS[i][15:8])
            `CHK(h, ROWS[i][0])
        end
        $display("register rows done");
        sfr_wr(8'h8a, 8'h11, 8'h01);
        sfr_rd(8'h8a, 8'h01, d, h);
        `CHK(h, 1'b0)
        sfr_rd(8'h8a, 8'h02, d, h);
        `CHK(d, 8'h00)
        $display("wrong page done");
        sfr_wr(8'h9d, 8'h0f, 8'h02);
        sfr_wr(8'h9e, 8'h50, 8'h02);
        sfr_wr(8'h9f, 8'h01, 8'h02);
        sfr_wr(8'ha2, 8'h00, 8'h02);
        sfr_wr(8'ha3, 8'h01, 8'h02);
        sfr_wr(8'h89, 8'ha5, 8'h02);
        sfr_wr(8'h8a, 8'h3c, 8'h02);
        sfr_wr(8'h8b, 8'hff, 8'h02);
        sfr_wr(8'h8c, 8'h0f, 8'h02);
        sfr_wr(8'h91, 8'h00, 8'h02);
        sfr_wr(8'h93, 8'hff, 8'h02);
        `CHK(bias_en, 1'b1)
        `CHK(cmp_dis, 1'b1)
        `CHK(contrast, 8'h77)
        show(8'h0f);
        `CHK(drive_en, 1'b0)
        `CHK(lit, 128'h0)
        sfr_wr(8'h9e, 8'h51, 8'h02);
        $display("setup done");
        for (int m = 0; m < 4; m++) begin
            nm = 4'((5'h2 << m) - 5'h1);
            show(8'h09 | 8'(m << 1));
            `CHK(lit[31:0], 32'h0fff3ca5 & {8{nm}})
            `CHK(lit[71:64], {2{nm}})
            `CHK(pin_en, 32'hffffffff)
            `CHK(bias_half, (m != 0))
            steps1 = steps;
        end
        show(8'h0e);
        `CHK(lit[31:0], 32'h0fff3ca5)
        `CHK(bias_half, 1'b0)
        $display("mux modes done");
        show(8'h1f);
        `CHK(lit, 128'h0)
        show(8'h07);
        `CHK(pin_en, 32'h0000ffff)
        `CHK(lit[71:64], 8'h00)
        `CHK(lit[31:0], 32'h0fff3ca5)
        show(8'h4f);
        `CHK(steps * 3 < steps1 && steps1 < steps * 5, 1'b1)
        show(8'h6f);
        `CHK(steps, 16'h0)
        sfr_wr(8'h89, 8'h5a, 8'h02);
        show(8'h0f);
        `CHK(lit[7:0], 8'h5a)
        sfr_wr(8'ha4, 8'h01, 8'h02);
        sfr_wr(8'ha5, 8'h40, 8'h02);
        sfr_wr(8'h9e, 8'h50, 8'h02);
        sfr_wr(8'h9d, 8'h08, 8'h02);
        sfr_wr(8'h9e, 8'h51, 8'h02);
        // blink phase flips about 2145 cycles after enable
        show(8'h08);
        `CHK(lit[31:0], 32'h01111010)
        repeat (1000) @(posedge mclk);
        show(8'h08);
        `CHK(lit[31:0], 32'h01110000)
        $display("blink done");
        sfr_wr(8'h9f, 8'h00, 8'h02);
        sfr_wr(8'h9e, 8'h50, 8'h02);
        @(posedge mclk);
        #1;
        `CHK(cmp_dis, 1'b0)
        `CHK(drive_en, 1'b0)
        $display("display checks done");
        @(posedge mclk);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        sfr_rd(8'h9e, 8'h02, d, h);
        `CHK(d, 8'h00)
        `CHK(drive_en, 1'b0)
        $display("mid-run reset done");
        tally_and_finish();
    end
endmodule : lcd_segment_driver_test
`default_nettype wire
